// >>> arc_pkg.sv
package arc_pkg;
   // Configuration lock state
   typedef enum logic [2:0] {
      CFG_NONE  = 3'b001,
      CFG_INDEP = 3'b010,
      CFG_SHARE = 3'b100
   } arc_cfg_t;

   // Chip operating modes seen by the block
   typedef enum logic [2:0] {
      MODE_INIT     = 3'h0,
      MODE_NORMAL   = 3'h1,
      MODE_STOP     = 3'h2,
      MODE_SLEEP    = 3'h3,
      MODE_RESTART  = 3'h4,
      MODE_FAILSAFE = 3'h5
   } arc_mode_t;

   // Software control bits, written by the SPI register layer
   typedef struct packed {
      logic auxIndependentEnable;
      logic auxLoadShareEnable;
      logic loadShareKeepInStop;
      logic auxKeepOnSupplyLow;
      logic auxVoltageSelect;
   } arc_ctrl_t;

   // Status bits read back by software
   typedef struct packed {
      logic auxOvercurrentFlag;
      logic auxUndervoltageFlag;
      logic configErrorPulse;
   } arc_stat_t;

   localparam logic RST_KEEP_IN_STOP = 1'b0;
   localparam logic RST_OC_FLAG = 1'b0;
   localparam logic RST_UV_FLAG = 1'b0;
   localparam logic VSEL_5V0 = 1'b0;
   localparam logic VSEL_3V3 = 1'b1;
endpackage

// >>> arc_sticky_flag.sv
`timescale 1ns/1ps
// Sticky flag: set wins over clear; clear only acts once the cause is gone
module arc_sticky_flag #(
   parameter logic RESET_VALUE = 1'b0
) (
   input wire logic ref_clk,    // clock
   input wire logic arst_n,     // async reset
   input wire logic setCond,    // condition present
   input wire logic clearReq,   // clear request pulse
   output logic flag            // sticky flag
);
   logic next_flag;

   assign next_flag = setCond ? 1'b1 : (clearReq ? 1'b0 : flag);

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         flag <= RESET_VALUE;
      end else begin
         flag <= next_flag;
      end
   end
endmodule // arc_sticky_flag

// >>> arc_aux_regulator_ctrl.sv
`timescale 1ns/1ps
module arc_aux_regulator_ctrl (
   input wire logic ref_clk,                     // 25 MHz clock
   input wire logic arst_n,                      // power-on reset
   input wire logic softReset,                   // chip soft reset pulse
   input wire arc_pkg::arc_mode_t chipMode,      // chip mode
   input wire arc_pkg::arc_ctrl_t ctrl,          // control bits
   input wire logic ctrlWrite,                   // one-cycle write strobe for ctrl
   input wire logic ocClear,                     // clear overcurrent flag pulse
   input wire logic uvClear,                     // clear undervoltage flag pulse
   input wire logic shuntThresholdHit,           // shunt comparator output
   input wire logic auxOutputLow,                // output undervoltage comparator
   input wire logic supplyBelowUv,               // supply below supply_undervoltage_level
   output logic auxDriveEnable,                  // regulator pass drive enable
   output logic auxCurrentLimit,                 // current limitation active
   output logic auxVoltage3v3,                   // 1: 3.3 V target, 0: 5.0 V
   output arc_pkg::arc_cfg_t cfgState,           // locked configuration
   output arc_pkg::arc_stat_t status,            // status flags
   output logic loadShareKeepInStop              // stored keep-in-stop bit
);
   arc_pkg::arc_cfg_t next_cfgState;
   logic indepOn;
   logic next_indepOn;
   logic next_keep;
   logic keepOnLow;
   logic next_keepOnLow;
   logic vsel;
   logic next_vsel;
   logic cfgError;
   logic ocFlag;
   logic uvFlag;

   wire logic isIndep;
   wire logic isShare;
   wire logic inNormal;
   wire logic inStop;
   wire logic inFailSafe;
   wire logic inOff;
   wire logic pickIndep;
   wire logic pickShare;
   wire logic shareChange;

   assign isIndep = (cfgState == arc_pkg::CFG_INDEP);
   assign isShare = (cfgState == arc_pkg::CFG_SHARE);
   assign inNormal = (chipMode == arc_pkg::MODE_NORMAL);
   assign inStop = (chipMode == arc_pkg::MODE_STOP);
   assign inFailSafe = (chipMode == arc_pkg::MODE_FAILSAFE);
   // INIT keeps the regulator dark just as Fail-Safe does
   assign inOff = (chipMode == arc_pkg::MODE_INIT) || inFailSafe;

   // Configuration selection; writes after the lock never move it
   assign pickIndep = ctrlWrite && (cfgState == arc_pkg::CFG_NONE) && inNormal
      && ctrl.auxIndependentEnable && !ctrl.auxLoadShareEnable;
   // Load sharing wins when both enables arrive in one write
   assign pickShare = ctrlWrite && (cfgState == arc_pkg::CFG_NONE)
      && ctrl.auxLoadShareEnable;
   // In the load-sharing lock, any write that sets the independent enable or clears the load-sharing enable counts as a change attempt
   assign shareChange = ctrlWrite && isShare
      && (ctrl.auxIndependentEnable || !ctrl.auxLoadShareEnable);

   assign next_cfgState = pickShare ? arc_pkg::CFG_SHARE :
      (pickIndep ? arc_pkg::CFG_INDEP : cfgState);

   // Independent on/off stays writable after the lock
   assign next_indepOn = (ctrlWrite && isIndep) ? ctrl.auxIndependentEnable :
      (pickIndep ? 1'b1 : indepOn);
   assign next_keep = ctrlWrite ? ctrl.loadShareKeepInStop : loadShareKeepInStop;
   assign next_keepOnLow = ctrlWrite ? ctrl.auxKeepOnSupplyLow : keepOnLow;
   // Voltage select is frozen only in the load-sharing configuration
   assign next_vsel = (ctrlWrite && !isShare) ? ctrl.auxVoltageSelect : vsel;

   // Lock lives only on power-on reset; soft reset leaves it alone
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfgState <= arc_pkg::CFG_NONE;
      end else begin
         cfgState <= next_cfgState;
      end
   end

   // Soft reset drops the switch-on request but not the configuration
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         indepOn <= 1'b0;
      end else if (softReset) begin
         indepOn <= 1'b0;
      end else begin
         indepOn <= next_indepOn;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         loadShareKeepInStop <= arc_pkg::RST_KEEP_IN_STOP;
      end else if (softReset) begin
         loadShareKeepInStop <= arc_pkg::RST_KEEP_IN_STOP;
      end else begin
         loadShareKeepInStop <= next_keep;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         keepOnLow <= 1'b0;
      end else if (softReset) begin
         keepOnLow <= 1'b0;
      end else begin
         keepOnLow <= next_keepOnLow;
      end
   end

   // Soft reset keeps the chosen output level
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         vsel <= arc_pkg::VSEL_5V0;
      end else if (!softReset) begin
         vsel <= next_vsel;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfgError <= 1'b0;
      end else if (softReset) begin
         cfgError <= 1'b0;
      end else begin
         cfgError <= shareChange;
      end
   end

   // Mode gating of the output
   wire logic supplyGate;
   wire logic shareRun;
   wire logic indepRun;
   wire logic next_drive;
   wire logic ocCond;
   wire logic uvCond;

   assign supplyGate = !supplyBelowUv || keepOnLow;
   assign shareRun = isShare && (inNormal
      || (inStop && loadShareKeepInStop));
   // Independent output keeps its switch state in Stop, Sleep and Restart
   assign indepRun = isIndep && indepOn && !inOff;
   assign next_drive = !inFailSafe && supplyGate && (shareRun || indepRun);

   // Current limit and undervoltage only in the independent configuration
   // Both need the drive on, so a fault is only detected while auxDriveEnable is high
   assign ocCond = isIndep && auxDriveEnable && shuntThresholdHit;
   assign uvCond = isIndep && auxDriveEnable && auxOutputLow;

   arc_sticky_flag #(
      .RESET_VALUE(arc_pkg::RST_OC_FLAG)
   ) u_ocFlag (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .setCond(ocCond),
      .clearReq(ocClear),
      .flag(ocFlag)
   );

   arc_sticky_flag #(
      .RESET_VALUE(arc_pkg::RST_UV_FLAG)
   ) u_uvFlag (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .setCond(uvCond),
      .clearReq(uvClear),
      .flag(uvFlag)
   );

   // Looks at the next configuration so the load-sharing lock cycle never shows 3.3 V
   wire logic show3v3;
   assign show3v3 = (next_cfgState != arc_pkg::CFG_SHARE)
      && (vsel == arc_pkg::VSEL_3V3);

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         auxDriveEnable <= 1'b0;
      end else begin
         auxDriveEnable <= next_drive;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         auxCurrentLimit <= 1'b0;
      end else begin
         auxCurrentLimit <= ocCond;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         auxVoltage3v3 <= 1'b0;
      end else begin
         auxVoltage3v3 <= show3v3;
      end
   end

   // Status word is wired straight from the flag registers
   assign status.auxOvercurrentFlag = ocFlag;
   assign status.auxUndervoltageFlag = uvFlag;
   assign status.configErrorPulse = cfgError;
endmodule // arc_aux_regulator_ctrl

// >>> arc_aux_regulator_ctrl_assertions.sv
`timescale 1ns/1ps
module arc_aux_regulator_ctrl_assertions (
   input wire logic ref_clk, // clock
   input wire logic arst_n, // reset
   input wire logic softReset, // soft reset
   input wire arc_pkg::arc_mode_t chipMode, // mode
   input wire arc_pkg::arc_ctrl_t ctrl, // control
   input wire logic ctrlWrite, // write
   input wire logic shuntThresholdHit, // shunt
   input wire logic auxDriveEnable, // drive
   input wire logic auxCurrentLimit, // limit
   input wire logic auxVoltage3v3, // vsel
   input wire arc_pkg::arc_cfg_t cfgState, // lock
   input wire arc_pkg::arc_stat_t status, // flags
   input wire logic loadShareKeepInStop // keep
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   wire share = cfgState == arc_pkg::CFG_SHARE;
   wire bad = ctrl.auxIndependentEnable || !ctrl.auxLoadShareEnable;
   sequence stopPause;
      (share && chipMode == arc_pkg::MODE_STOP && !loadShareKeepInStop) [*2];
   endsequence
   a_share_no_oc: assert property (share |-> !status.auxOvercurrentFlag && !auxCurrentLimit)
      else $error("overcurrent in load sharing");
   a_share_no_uv: assert property (share |-> !status.auxUndervoltageFlag)
      else $error("undervoltage in load sharing");
   a_failsafe_off: assert property (chipMode == arc_pkg::MODE_FAILSAFE |=> !auxDriveEnable)
      else $error("drive on in fail-safe");
   a_lock_stays: assert property (cfgState != arc_pkg::CFG_NONE |=> $stable(cfgState))
      else $error("lock changed");
   a_indep_quiet: assert property (cfgState == arc_pkg::CFG_INDEP |-> !status.configErrorPulse)
      else $error("error in independent lock");
   a_share_error: assert property (share && ctrlWrite && bad && !softReset |=> status.configErrorPulse)
      else $error("no config error");
   a_oc_sets: assert property (!share && auxDriveEnable && shuntThresholdHit |=> status.auxOvercurrentFlag)
      else $error("overcurrent not flagged");
   a_share_vsel: assert property (share |-> !auxVoltage3v3)
      else $error("vsel used in load sharing");
   a_stop_pause: assert property (stopPause |-> !auxDriveEnable)
      else $error("sharing on in stop");
endmodule // arc_aux_regulator_ctrl_assertions
bind arc_aux_regulator_ctrl arc_aux_regulator_ctrl_assertions i_chk (.*);

// >>> test_arc_aux_regulator_ctrl.sv
`timescale 1ns/1ps
module test_arc_aux_regulator_ctrl;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic softReset = 1'b0;
   arc_pkg::arc_mode_t chipMode = arc_pkg::MODE_NORMAL;
   arc_pkg::arc_ctrl_t ctrl = '0;
   logic ctrlWrite = 1'b0;
   logic ocClear = 1'b0;
   logic uvClear = 1'b0;
   logic shuntThresholdHit = 1'b0;
   logic auxOutputLow = 1'b0;
   logic supplyBelowUv = 1'b0;
   logic auxDriveEnable, auxCurrentLimit, auxVoltage3v3, loadShareKeepInStop;
   arc_pkg::arc_cfg_t cfgState;
   arc_pkg::arc_stat_t status;
   int nMismatch = 0;
   int totalChecks = 0;
   arc_aux_regulator_ctrl i_arc_aux_regulator_ctrl (.*);
   initial forever #20 ref_clk = ~ref_clk;
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [4:0] v);
      @(posedge ref_clk);
      ctrl <= v;
      ctrlWrite <= 1'b1;
      @(posedge ref_clk);
      ctrlWrite <= 1'b0;
      #1;
   endtask
   // Levels change together; both clear pulses last one cycle
   task automatic drv(input logic [2:0] m, input logic h, input logic l, input logic s, input logic c);
      @(posedge ref_clk);
      chipMode <= arc_pkg::arc_mode_t'(m);
      shuntThresholdHit <= h;
      auxOutputLow <= l;
      supplyBelowUv <= s;
      ocClear <= c;
      uvClear <= c;
      @(posedge ref_clk);
      ocClear <= 1'b0;
      uvClear <= 1'b0;
      step(1);
   endtask
   task automatic chkB(input logic g, input logic e);
      totalChecks++;
      if (g !== e) begin
         nMismatch++;
         $display("[FAIL] %0t bit %b expected %b", $time, g, e);
      end
   endtask
   task automatic chkC(input arc_pkg::arc_cfg_t g, input arc_pkg::arc_cfg_t e);
      totalChecks++;
      if (g !== e) begin
         nMismatch++;
         $display("[FAIL] %0t cfg %b expected %b", $time, g, e);
      end
   endtask
   task automatic wrapUp;
      $display("checks %0d mismatches %0d", totalChecks, nMismatch);
      if (nMismatch == 0 && totalChecks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge ref_clk);
      arst_n <= 1'b1;
      step(1);
      chkC(cfgState, arc_pkg::CFG_NONE);
      wr(5'h11);
      step(1);
      chkC(cfgState, arc_pkg::CFG_INDEP);
      chkB(auxVoltage3v3, 1'b1);
      wr(5'h19);
      chkB(status.configErrorPulse, 1'b0);
      chkC(cfgState, arc_pkg::CFG_INDEP);
      wr(5'h01);
      step(1);
      chkB(auxDriveEnable, 1'b0);
      wr(5'h10);
      drv(3'h1, 1'b1, 1'b0, 1'b0, 1'b0);
      chkB(status.auxOvercurrentFlag, 1'b1);
      chkB(auxCurrentLimit, 1'b1);
      drv(3'h1, 1'b1, 1'b0, 1'b0, 1'b1);
      drv(3'h1, 1'b0, 1'b0, 1'b0, 1'b0);
      chkB(status.auxOvercurrentFlag, 1'b1);
      drv(3'h1, 1'b0, 1'b1, 1'b0, 1'b1);
      chkB(status.auxOvercurrentFlag, 1'b0);
      chkB(status.auxUndervoltageFlag, 1'b1);
      drv(3'h1, 1'b0, 1'b0, 1'b1, 1'b1);
      chkB(auxDriveEnable, 1'b0);
      chkB(status.auxUndervoltageFlag, 1'b0);
      drv(3'h1, 1'b0, 1'b0, 1'b0, 1'b0);
      chkB(auxDriveEnable, 1'b1);
      wr(5'h12);
      drv(3'h1, 1'b0, 1'b0, 1'b1, 1'b0);
      chkB(auxDriveEnable, 1'b1);
      drv(3'h5, 1'b0, 1'b0, 1'b0, 1'b0);
      chkB(auxDriveEnable, 1'b0);
      @(posedge ref_clk);
      softReset <= 1'b1;
      @(posedge ref_clk);
      softReset <= 1'b0;
      step(1);
      chkC(cfgState, arc_pkg::CFG_INDEP);
      $display("independent test done");
      drv(3'h1, 1'b0, 1'b0, 1'b0, 1'b0);
      wr(5'h04);
      chkB(loadShareKeepInStop, 1'b1);
      @(posedge ref_clk);
      arst_n <= 1'b0;
      @(posedge ref_clk);
      arst_n <= 1'b1;
      step(1);
      chkB(loadShareKeepInStop, 1'b0);
      chkC(cfgState, arc_pkg::CFG_NONE);
      wr(5'h08);
      chkC(cfgState, arc_pkg::CFG_SHARE);
      step(1);
      chkB(auxDriveEnable, 1'b1);
      wr(5'h00);
      chkB(status.configErrorPulse, 1'b1);
      chkC(cfgState, arc_pkg::CFG_SHARE);
      drv(3'h2, 1'b0, 1'b0, 1'b0, 1'b0);
      chkB(auxDriveEnable, 1'b0);
      drv(3'h1, 1'b0, 1'b0, 1'b0, 1'b0);
      chkB(auxDriveEnable, 1'b1);
      wr(5'h0c);
      drv(3'h2, 1'b1, 1'b1, 1'b0, 1'b0);
      chkB(auxDriveEnable, 1'b1);
      chkB(status.auxOvercurrentFlag, 1'b0);
      chkB(auxCurrentLimit, 1'b0);
      chkB(status.auxUndervoltageFlag, 1'b0);
      $display("load share test done");
      wrapUp();
   end
endmodule // test_arc_aux_regulator_ctrl
